// ### logic/nvm_page_program_controller.sv
/*
 * page buffer, protection and command sequencer between the cpu bus and the nonvolatile arrays.
 * assumes an APB master on clk, a cpu store/load port on clk, same-clock fuse levels and an array
 * that performs each nv_port byte strobe.
 */
`timescale 1ns/1ps
`include "nvm_defs.svh"
module nvm_page_program_controller import nvm_pkg::*; #(
	parameter int FLASH_BYTES = 8192,
	parameter int FLASH_PAGE = 64,
	parameter int EE_BYTES = 128,
	parameter int EE_PAGE = 32
) (
	input wire logic clk, // 200 MHz clock
	input wire logic sys_rst, // synchronous reset
	input wire logic psel, // apb select
	input wire logic penable, // apb enable
	input wire logic pwrite, // apb direction
	input wire logic [11:0] paddr, // apb byte address
	input wire logic [31:0] pwdata, // apb write data
	output logic [31:0] prdata, // apb read data
	output logic pready, // apb ready
	output logic pslverr, // apb error on unmapped
	input wire logic dbgAccess, // access comes from the debug port
	input wire mem_req_type memReq, // cpu store or load
	input wire logic [7:0] memRdataIn, // array read data
	output logic [7:0] memRdata, // load data to cpu
	output logic memWait, // bus wait state
	input wire section_type execSection, // section code runs from
	input wire logic wakeUp, // wake from sleep pulse
	input wire logic [7:0] bootEndFuse, // boot end fuse
	input wire logic [7:0] codeEndFuse, // code end fuse
	input wire logic eepromKeepOnErase, // keep eeprom on chip erase
	output nv_port_type nvPort, // array byte strobe
	output fuse_wr_type fuseWr, // fuse write strobe
	output logic cpuHalt // halts the cpu
);
	localparam int IW = $clog2(FLASH_PAGE);
	localparam logic [15:0] STEP_LAST = 16'(`STEP_CYC - 1);
	state_type state_r;
	logic [7:0] buf_r [FLASH_PAGE];
	logic [FLASH_PAGE-1:0] mark_r;
	logic [15:0] pageAddr_r, addrReg_r, dataReg_r, idx_r, stepCnt_r, lastIdx_r;
	logic [7:0] boot_end_fuse_r, codeEnd_r;
	logic keep_r, codeWp_r, boot_read_lock_r, ccpOpen_r, busyF_r, busyE_r, wrErr_r, eeprom_ready_irq_r, eeIrqEn_r;
	logic eraseThenProg_r, opHalt_r;
	logic [2:0] ccpCnt_r;
	region_type tgt_r, storeRgn, cmdRgn;
	section_type cmdSec;
	nv_port_type nv_nxt;
	logic apbSetup, apbWr, mapped, cmdWr, cmdGo, deny, storeOk, bufClear, lastStep, stepDone;
	logic [3:0] idx;
	logic [2:0] cmd;
	logic [IW-1:0] storeIdx;

	function automatic region_type regionOf(input logic [15:0] a);
		if (a >= `FLASH_BASE && a - `FLASH_BASE < 16'(FLASH_BYTES))
			return R_FLASH;
		else if (a >= `EE_BASE && a - `EE_BASE < 16'(EE_BYTES))
			return R_EE;
		else if (a >= `USER_BASE && a - `USER_BASE < 16'(EE_PAGE))
			return R_USER;
		return R_NONE;
	endfunction

	// section from 256-byte block number of the flash offset
	function automatic section_type sectionOf(input logic [15:0] a, input logic [7:0] be, input logic [7:0] ce);
		logic [7:0] blk;
		blk = 8'((a - `FLASH_BASE) / `SECTION_BLOCK);
		// zero fuses widen boot or code section
		if (be == 8'h00 && ce == 8'h00)
			return SEC_BOOT;
		if (blk < be)
			return SEC_BOOT;
		if (ce == 8'h00 || blk < ce)
			return SEC_CODE;
		return SEC_DATA;
	endfunction

	// apb decode, zero wait states
	assign idx = paddr[5:2];
	assign apbSetup = psel && !penable;
	assign apbWr = psel && penable && pwrite;
	assign mapped = paddr[11:6] == 6'h00 && paddr[1:0] == 2'h0 && idx != 4'h5 && idx != 4'h7
		&& idx <= `IDX_CCP && !(idx > `IDX_ADDR && idx < `IDX_CCP);
	assign pready = 1'b1;
	assign pslverr = psel && penable && !mapped;
	assign cmd = pwdata[2:0];
	assign cmdWr = apbWr && mapped && idx == `IDX_CTRLA;
	// command taken only inside the window, idle and not busy
	assign cmdGo = cmdWr && ccpOpen_r && state_r == S_IDLE && cmd != `CMD_NONE
		// fuse write refused unless the debug port issues it
		&& (cmd != `CMD_FUSE_WRITE || dbgAccess);

	// read data latched in the setup phase
	always_ff @(posedge clk)
	begin
		if (sys_rst)
			prdata <= 32'h0;
		else if (apbSetup && !pwrite)
			unique case (idx)
				`IDX_CTRLB: prdata <= {30'h0, boot_read_lock_r, codeWp_r};
				`IDX_STATUS: prdata <= {29'h0, wrErr_r, busyE_r, busyF_r};
				`IDX_INTCTRL: prdata <= {31'h0, eeIrqEn_r};
				`IDX_INTFLAGS: prdata <= {31'h0, eeprom_ready_irq_r};
				`IDX_DATA: prdata <= {16'h0, dataReg_r};
				`IDX_ADDR: prdata <= {16'h0, addrReg_r};
				`IDX_CCP: prdata <= {30'h0, ccpOpen_r, 1'b0};
				default: prdata <= 32'h0;
			endcase
	end

	// key opens a short window, any command write closes it
	always_ff @(posedge clk)
	begin
		if (sys_rst)
		begin
			ccpOpen_r <= 1'b0;
			ccpCnt_r <= 3'h0;
		end
		else if (apbWr && mapped && idx == `IDX_CCP && pwdata[7:0] == `SPM_KEY)
		begin
			ccpOpen_r <= 1'b1;
			ccpCnt_r <= 3'(`CCP_CYC - 1);
		end
		else if (cmdWr || ccpCnt_r == 3'h0)
			ccpOpen_r <= 1'b0;
		else
			ccpCnt_r <= ccpCnt_r - 3'h1;
	end

	// protect bits only set, cleared by reset; lock written from boot only
	always_ff @(posedge clk)
	begin
		if (sys_rst)
		begin
			codeWp_r <= 1'b0;
			boot_read_lock_r <= 1'b0;
			eeIrqEn_r <= 1'b0;
			addrReg_r <= 16'h0;
			dataReg_r <= 16'h0;
		end
		else if (apbWr && mapped)
		begin
			if (idx == `IDX_CTRLB)
			begin
				codeWp_r <= codeWp_r | pwdata[`CTRLB_WP_BIT];
				boot_read_lock_r <= boot_read_lock_r | (pwdata[`CTRLB_LOCK_BIT] && execSection == SEC_BOOT);
			end
			if (idx == `IDX_INTCTRL)
				eeIrqEn_r <= pwdata[0];
			if (idx == `IDX_ADDR)
				addrReg_r <= pwdata[15:0];
			if (idx == `IDX_DATA)
				dataReg_r <= pwdata[15:0];
		end
	end

	// fuses are taken while reset holds, so a new fuse acts after reset
	always_ff @(posedge clk)
	begin
		if (sys_rst)
		begin
			boot_end_fuse_r <= bootEndFuse;
			codeEnd_r <= codeEndFuse;
			keep_r <= eepromKeepOnErase;
		end
	end

	// cpu port: loads and stores wait while an operation runs
	assign storeRgn = regionOf(memReq.addr);
	assign storeIdx = memReq.addr[IW-1:0];
	assign storeOk = memReq.req && memReq.write && storeRgn != R_NONE && state_r == S_IDLE;
	assign memWait = memReq.req && storeRgn != R_NONE && state_r != S_IDLE;
	// locked boot section reads as zero outside boot
	assign memRdata = (boot_read_lock_r && execSection != SEC_BOOT && storeRgn == R_FLASH
		&& sectionOf(memReq.addr, boot_end_fuse_r, codeEnd_r) == SEC_BOOT) ? 8'h00 : memRdataIn;

	// page address follows the last store
	always_ff @(posedge clk)
	begin
		if (sys_rst)
			pageAddr_r <= 16'h0;
		else if (storeOk)
			pageAddr_r <= memReq.addr;
	end

	// buffer back to ones on reset, completed page write, page erase and buffer clear, and wake
	assign bufClear = sys_rst || wakeUp || (stepDone && lastStep
		&& (state_r == S_PROG || state_r == S_CLEAR || (state_r == S_ERASE && !eraseThenProg_r)));
	genvar g;
	generate
		for (g = 0; g < FLASH_PAGE; g++)
		begin : gBuf
			// store merges by AND and marks the byte
			always_ff @(posedge clk)
			begin
				if (bufClear)
				begin
					buf_r[g] <= 8'hFF;
					mark_r[g] <= 1'b0;
				end
				else if (storeOk && storeIdx == IW'(g))
				begin
					buf_r[g] <= buf_r[g] & memReq.wdata;
					mark_r[g] <= 1'b1;
				end
			end
		end
	endgenerate

	// directional protection for page commands, a denied one only sets the write error
	assign cmdRgn = regionOf(pageAddr_r);
	assign cmdSec = sectionOf(pageAddr_r, boot_end_fuse_r, codeEnd_r);
	always_comb
	begin
		deny = 1'b0;
		if (cmdRgn == R_NONE)
			deny = 1'b1;
		else if (cmdRgn == R_FLASH)
			unique case (cmdSec)
				SEC_BOOT: deny = !dbgAccess || boot_read_lock_r;
				SEC_CODE: deny = codeWp_r || (!dbgAccess && execSection != SEC_BOOT);
				default: deny = !dbgAccess && execSection == SEC_DATA;
			endcase
		// the debug port reaches the user row regardless of the cpu section
		else
			deny = !dbgAccess && execSection == SEC_DATA;
	end

	// step timing: STEP_CYC cycles per byte, the byte strobe in the first
	assign stepDone = state_r == S_CLEAR ? stepCnt_r == 16'(`CLEAR_CYC - 1) : stepCnt_r == STEP_LAST;
	assign lastStep = state_r == S_CLEAR || state_r == S_FUSE || idx_r == lastIdx_r;

	// sequencer; synchronous reset drops any operation at once
	always_ff @(posedge clk)
	begin
		if (sys_rst)
		begin
			state_r <= S_IDLE;
			idx_r <= 16'h0;
			stepCnt_r <= 16'h0;
			lastIdx_r <= 16'h0;
			tgt_r <= R_NONE;
			eraseThenProg_r <= 1'b0;
			opHalt_r <= 1'b0;
			busyF_r <= 1'b0;
			busyE_r <= 1'b0;
			wrErr_r <= 1'b0;
		end
		else if (state_r == S_IDLE)
		begin
			idx_r <= 16'h0;
			stepCnt_r <= 16'h0;
			if (cmdGo)
			begin
				wrErr_r <= 1'b0;
				tgt_r <= cmdRgn;
				lastIdx_r <= 16'(cmdRgn == R_FLASH ? FLASH_PAGE - 1 : EE_PAGE - 1);
				opHalt_r <= cmdRgn == R_FLASH;
				eraseThenProg_r <= cmd == `CMD_ERASE_WRITE;
				unique case (cmd)
					`CMD_PAGE_WRITE, `CMD_PAGE_ERASE, `CMD_ERASE_WRITE:
					begin
						if (deny)
							wrErr_r <= 1'b1;
						else if (cmd != `CMD_PAGE_ERASE || mark_r != '0)
						begin
							state_r <= cmd == `CMD_PAGE_WRITE ? S_PROG : S_ERASE;
							busyF_r <= cmdRgn == R_FLASH;
							busyE_r <= cmdRgn != R_FLASH;
						end
					end
					`CMD_BUF_CLEAR:
					begin
						state_r <= S_CLEAR;
						opHalt_r <= 1'b1;
					end
					`CMD_CHIP_ERASE:
					begin
						state_r <= S_CHIP;
						opHalt_r <= 1'b1;
						lastIdx_r <= 16'(keep_r ? FLASH_BYTES - 1 : FLASH_BYTES + EE_BYTES - 1);
						busyF_r <= 1'b1;
						busyE_r <= !keep_r;
					end
					`CMD_EE_ERASE:
					begin
						state_r <= S_EEALL;
						opHalt_r <= 1'b1;
						lastIdx_r <= 16'(EE_BYTES - 1);
						busyE_r <= 1'b1;
					end
					default:
					begin
						state_r <= S_FUSE;
						opHalt_r <= 1'b1;
					end
				endcase
			end
		end
		else if (stepDone)
		begin
			stepCnt_r <= 16'h0;
			idx_r <= idx_r + 16'h1;
			if (lastStep)
			begin
				idx_r <= 16'h0;
				// erase phase hands over to write without clearing
				if (state_r == S_ERASE && eraseThenProg_r)
					state_r <= S_PROG;
				else
				begin
					state_r <= S_IDLE;
					busyF_r <= 1'b0;
					busyE_r <= 1'b0;
				end
			end
		end
		else
			stepCnt_r <= stepCnt_r + 16'h1;
	end

	// flash page operations, buffer clear, chip and eeprom erase and fuse write halt the cpu; eeprom and user row page ones let it run
	assign cpuHalt = state_r != S_IDLE && opHalt_r;

	// byte strobe for the current step
	always_comb
	begin
		nv_nxt = '0;
		nv_nxt.addr = (pageAddr_r & ~16'(tgt_r == R_FLASH ? FLASH_PAGE - 1 : EE_PAGE - 1)) + idx_r;
		nv_nxt.data = buf_r[idx_r[IW-1:0]];
		if (stepCnt_r == 16'h0)
			unique case (state_r)
				// eeprom and user row touch marked bytes only
				// eeprom page erase limited to marked bytes
				S_ERASE:
				begin
					nv_nxt.en = tgt_r == R_FLASH || mark_r[idx_r[IW-1:0]];
					nv_nxt.erase = 1'b1;
					nv_nxt.data = 8'hFF;
				end
				S_PROG: nv_nxt.en = tgt_r == R_FLASH || mark_r[idx_r[IW-1:0]];
				// chip erase walks flash, then eeprom unless keep is set, never the user row
				S_CHIP:
				begin
					nv_nxt.en = 1'b1;
					nv_nxt.erase = 1'b1;
					nv_nxt.data = 8'hFF;
					nv_nxt.addr = idx_r < 16'(FLASH_BYTES) ? `FLASH_BASE + idx_r : `EE_BASE + idx_r - 16'(FLASH_BYTES);
				end
				S_EEALL:
				begin
					nv_nxt.en = 1'b1;
					nv_nxt.erase = 1'b1;
					nv_nxt.data = 8'hFF;
					nv_nxt.addr = `EE_BASE + idx_r;
				end
				default: nv_nxt = '0;
			endcase
	end

	// array and fuse strobes from flops
	always_ff @(posedge clk)
	begin
		if (sys_rst)
		begin
			nvPort <= '0;
			fuseWr <= '0;
		end
		else
		begin
			nvPort <= nv_nxt;
			fuseWr.en <= state_r == S_FUSE && stepCnt_r == 16'h0;
			fuseWr.addr <= addrReg_r;
			fuseWr.data <= dataReg_r[7:0];
		end
	end

	// ready flag set when eeprom busy ends; set wins over write-one-clear
	always_ff @(posedge clk)
	begin
		if (sys_rst)
			eeprom_ready_irq_r <= 1'b0;
		else if (busyE_r && stepDone && lastStep && !(state_r == S_ERASE && eraseThenProg_r))
			eeprom_ready_irq_r <= 1'b1;
		else if (apbWr && mapped && idx == `IDX_INTFLAGS && pwdata[0])
			eeprom_ready_irq_r <= 1'b0;
	end

	a_cmd_ignored: assert property (@(posedge clk) disable iff (sys_rst)
		(cmdWr && !ccpOpen_r) |=> $stable(state_r) && $stable(nvPort))
		else $error("command accepted without window");
	a_clear_halt: assert property (@(posedge clk) disable iff (sys_rst)
		($rose(state_r == S_CLEAR)) |-> cpuHalt [*7] ##1 state_r == S_IDLE)
		else $error("buffer clear halt not seven cycles");
	a_boot_never: assert property (@(posedge clk) disable iff (sys_rst)
		(nvPort.en && $past(state_r) != S_CHIP && regionOf(nvPort.addr) == R_FLASH && !$past(dbgAccess, 2)
		&& sectionOf(nvPort.addr, boot_end_fuse_r, codeEnd_r) == SEC_BOOT) |-> 1'b0)
		else $error("cpu wrote boot section");
	a_load_wait: assert property (@(posedge clk) disable iff (sys_rst)
		(memReq.req && storeRgn != R_NONE && busyF_r) |-> memWait)
		else $error("load not stalled while busy");
	a_busy_flag: assert property (@(posedge clk) disable iff (sys_rst)
		(cmdGo && !deny && cmd == `CMD_PAGE_WRITE && cmdRgn == R_EE) |=> busyE_r && !busyF_r && !cpuHalt)
		else $error("eeprom busy flag wrong");
	a_ready_flag: assert property (@(posedge clk) disable iff (sys_rst)
		$fell(busyE_r) |-> eeprom_ready_irq_r)
		else $error("eeprom ready flag not raised");
	a_fuse_port: assert property (@(posedge clk) disable iff (sys_rst)
		(cmdWr && ccpOpen_r && cmd == `CMD_FUSE_WRITE && !dbgAccess) |=> state_r == S_IDLE ##1 !fuseWr.en)
		else $error("fuse write from cpu");
	a_deny_error: assert property (@(posedge clk) disable iff (sys_rst)
		(cmdGo && deny && cmd == `CMD_PAGE_WRITE) |=> wrErr_r && state_r == S_IDLE)
		else $error("denied write started");
	a_merge_and: assert property (@(posedge clk) disable iff (sys_rst)
		(storeOk && !wakeUp) |=> buf_r[$past(storeIdx)] == ($past(buf_r[storeIdx]) & $past(memReq.wdata)))
		else $error("page buffer not AND merged");
	a_marked_only: assert property (@(posedge clk) disable iff (sys_rst)
		(nv_nxt.en && tgt_r != R_FLASH && (state_r == S_PROG || state_r == S_ERASE)) |-> mark_r[idx_r[IW-1:0]])
		else $error("unmarked eeprom byte touched");
endmodule

// ### include/nvm_defs.svh
/*
 * constants of the nonvolatile controller: register indexes, fields, commands, memory map and timing.
 * assumes an includer that needs plain `define values and no code.
 */
`ifndef NVM_DEFS_SVH
`define NVM_DEFS_SVH
// register indexes, byte address is four times the index
`define IDX_CTRLA 4'h0
`define IDX_CTRLB 4'h1
`define IDX_STATUS 4'h2
`define IDX_INTCTRL 4'h3
`define IDX_INTFLAGS 4'h4
`define IDX_DATA 4'h6
`define IDX_ADDR 4'h8
`define IDX_CCP 4'hC
// fields
`define CTRLB_WP_BIT 0
`define CTRLB_LOCK_BIT 1
`define CCP_SPM_BIT 1
`define SPM_KEY 8'h9D
// commands
`define CMD_NONE 3'h0
`define CMD_PAGE_WRITE 3'h1
`define CMD_PAGE_ERASE 3'h2
`define CMD_ERASE_WRITE 3'h3
`define CMD_BUF_CLEAR 3'h4
`define CMD_CHIP_ERASE 3'h5
`define CMD_EE_ERASE 3'h6
`define CMD_FUSE_WRITE 3'h7
// memory map
`define FLASH_BASE 16'h8000
`define EE_BASE 16'h1400
`define USER_BASE 16'h1300
`define SECTION_BLOCK 256
// timing
`define CLK_NS 5
`define STEP_NS 20
`define STEP_CYC ((`STEP_NS + `CLK_NS - 1) / `CLK_NS)
`define CLEAR_CYC 7
`define CCP_CYC 4
`endif

// ### include/nvm_pkg.sv
/*
 * types of the nonvolatile controller.
 * assumes nothing beyond a SystemVerilog compiler.
 */
package nvm_pkg;
	typedef enum logic [6:0] {
		S_IDLE = 7'h01, S_ERASE = 7'h02, S_PROG = 7'h04, S_CLEAR = 7'h08,
		S_CHIP = 7'h10, S_EEALL = 7'h20, S_FUSE = 7'h40
	} state_type;
	typedef enum logic [1:0] {R_NONE = 2'h0, R_FLASH = 2'h1, R_EE = 2'h2, R_USER = 2'h3} region_type;
	typedef enum logic [1:0] {SEC_BOOT = 2'h0, SEC_CODE = 2'h1, SEC_DATA = 2'h2} section_type;
	typedef struct packed {logic req; logic write; logic [15:0] addr; logic [7:0] wdata;} mem_req_type;
	typedef struct packed {logic en; logic erase; logic [15:0] addr; logic [7:0] data;} nv_port_type;
	typedef struct packed {logic en; logic [15:0] addr; logic [7:0] data;} fuse_wr_type;
endpackage

// ### verification/nv_array_model.sv
/*
 * byte array model of the flash, eeprom and user row behind the controller.
 * assumes one nvPort strobe per byte, and that an erase strobe leaves the byte at ones.
 */
`timescale 1ns/1ps
module nv_array_model import nvm_pkg::*; (
	input wire logic clk, // system clock
	input wire nv_port_type nvPort, // byte strobe from controller
	input wire logic [15:0] rdAddr, // cpu load address
	output logic [7:0] rdData // array read data
);
	logic [7:0] mem [logic [15:0]];
	// bytes never touched read as erased
	function automatic logic [7:0] peek(input logic [15:0] a);
		if (mem.exists(a))
			return mem[a];
		return 8'hFF;
	endfunction
	// programming only clears bits, so an unerased byte is corrupted as on silicon
	always @(posedge clk)
	begin
		if (nvPort.en === 1'b1)
			mem[nvPort.addr] = nvPort.erase ? 8'hFF : (peek(nvPort.addr) & nvPort.data);
	end
	// read port follows the address and every array update
	always @(rdAddr or posedge clk)
	begin
		rdData = peek(rdAddr);
	end
endmodule

// ### verification/tb_top.sv
/*
 * self-checking bench: apb register tasks, cpu store tasks and command sequences.
 * assumes the controller answers apb without wait states and the array model on its far side.
 */
`timescale 1ns/1ps
module tb_top import nvm_pkg::*;;
	logic clk, sysRst, psel, penable, pwrite, pready, pslverr, errVal;
	logic dbgAccess, wakeUp, keepEe, memWait, cpuHalt;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rdVal;
	logic [7:0] memRdataIn, memRdata, boot_end_fuse, codeEnd, fuseData;
	mem_req_type memReq;
	section_type execSection;
	nv_port_type nvPort;
	fuse_wr_type fuseWr;
	int nErrors, numChecks, nStrobe, nFuse, haltCnt;
	// smaller flash keeps the chip erase walk short
	nvm_page_program_controller #(.FLASH_BYTES(2048)) nvm_page_program_controller_inst (.clk(clk), .sys_rst(sysRst),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .dbgAccess(dbgAccess),
		.memReq(memReq), .memRdataIn(memRdataIn), .memRdata(memRdata), .memWait(memWait),
		.execSection(execSection), .wakeUp(wakeUp), .bootEndFuse(boot_end_fuse), .codeEndFuse(codeEnd),
		.eepromKeepOnErase(keepEe), .nvPort(nvPort), .fuseWr(fuseWr), .cpuHalt(cpuHalt));
	nv_array_model nv_array_model_inst (.clk(clk), .nvPort(nvPort), .rdAddr(memReq.addr),
		.rdData(memRdataIn));
	// 200 MHz clock
	initial
	begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end
	// strobe, fuse pulse and halt counters
	always @(posedge clk)
	begin
		if (nvPort.en === 1'b1)
			nStrobe++;
		if (fuseWr.en === 1'b1)
		begin
			nFuse++;
			fuseData = fuseWr.data;
		end
		if (cpuHalt === 1'b1)
			haltCnt++;
	end
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		numChecks++;
		if (got !== exp)
		begin
			nErrors++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic finalReport;
		$display("checks %0d mismatches %0d", numChecks, nErrors);
		if (nErrors == 0 && numChecks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	// one apb transfer, held until pready at a rising edge
	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
		@(posedge clk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		do @(posedge clk); while (pready !== 1'b1);
		rdVal = prdata;
		errVal = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic rdchk(input logic [11:0] a, input logic [31:0] exp, input logic [31:0] mask);
		apb(1'b0, a, 32'h00000000);
		chk(rdVal & mask, exp);
	endtask
	task automatic cmd(input logic [2:0] c);
		apb(1'b1, 12'h030, 32'h0000009D);
		apb(1'b1, 12'h000, {29'h00000000, c});
	endtask
	task automatic st(input logic [15:0] a, input logic [7:0] d);
		@(posedge clk);
		memReq <= '{1'b1, 1'b1, a, d};
		do @(posedge clk); while (memWait !== 1'b0);
		memReq.req <= 1'b0;
	endtask
	task automatic waitIdle;
		do apb(1'b0, 12'h008, 32'h00000000); while (rdVal[1:0] !== 2'b00);
	endtask
	task automatic pk(input logic [15:0] a, input logic [7:0] e);
		chk({24'h000000, nv_array_model_inst.peek(a)}, {24'h000000, e});
	endtask
	// watchdog far beyond the eleven thousand cycles the tests need
	initial
	begin
		#200000;
		nErrors++;
		finalReport;
	end
	initial
	begin
		{sysRst, psel, penable, pwrite, dbgAccess, wakeUp, keepEe} = 7'h40;
		{paddr, pwdata, memReq} = '0;
		{nErrors, numChecks, nStrobe, nFuse, haltCnt} = '0;
		execSection = SEC_BOOT;
		boot_end_fuse = 8'h04;
		codeEnd = 8'h08;
		repeat (16) @(posedge clk);
		sysRst <= 1'b0;
		rdchk(12'h008, 32'h00000000, 32'hFFFFFFFF);
		apb(1'b0, 12'h03C, 32'h00000000);
		chk({31'h0, errVal}, 32'h00000001);
		$display("test reset done");
		st(16'h1402, 8'h5A);
		st(16'h1402, 8'hF0);
		apb(1'b1, 12'h000, 32'h00000001);
		rdchk(12'h008, 32'h00000000, 32'h00000003);
		haltCnt = 0;
		cmd(3'h1);
		rdchk(12'h008, 32'h00000002, 32'h00000003);
		@(posedge clk);
		memReq <= '{1'b1, 1'b0, 16'h1402, 8'h00};
		#1 chk({31'h0, memWait}, 32'h00000001);
		memReq.req <= 1'b0;
		waitIdle;
		chk(nStrobe, 32'h00000001);
		pk(16'h1402, 8'h50);
		pk(16'h1403, 8'hFF);
		chk(haltCnt, 32'h00000000);
		rdchk(12'h010, 32'h00000001, 32'h00000001);
		apb(1'b1, 12'h010, 32'h00000001);
		rdchk(12'h010, 32'h00000000, 32'h00000001);
		$display("test eeprom write done");
		cmd(3'h6);
		waitIdle;
		pk(16'h1402, 8'hFF);
		chk({31'h0, haltCnt > 0}, 32'h00000001);
		st(16'h1406, 8'h00);
		@(posedge clk);
		wakeUp <= 1'b1;
		@(posedge clk);
		wakeUp <= 1'b0;
		nStrobe = 0;
		cmd(3'h1);
		waitIdle;
		chk(nStrobe, 32'h00000000);
		$display("test eeprom erase done");
		st(16'h8401, 8'h12);
		haltCnt = 0;
		cmd(3'h3);
		waitIdle;
		pk(16'h8401, 8'h12);
		pk(16'h8400, 8'hFF);
		chk({31'h0, haltCnt > 0}, 32'h00000001);
		$display("test flash erase write done");
		st(16'h8000, 8'h00);
		cmd(3'h1);
		waitIdle;
		pk(16'h8000, 8'hFF);
		rdchk(12'h008, 32'h00000004, 32'h00000004);
		haltCnt = 0;
		cmd(3'h4);
		repeat (12) @(posedge clk);
		chk(haltCnt, 32'h00000007);
		apb(1'b1, 12'h004, 32'h00000001);
		rdchk(12'h004, 32'h00000001, 32'h00000003);
		st(16'h8402, 8'h00);
		cmd(3'h1);
		waitIdle;
		pk(16'h8402, 8'hFF);
		cmd(3'h4);
		execSection <= SEC_DATA;
		st(16'h1404, 8'h00);
		cmd(3'h1);
		waitIdle;
		pk(16'h1404, 8'hFF);
		cmd(3'h4);
		execSection <= SEC_BOOT;
		$display("test protection done");
		apb(1'b1, 12'h020, 32'h00000001);
		apb(1'b1, 12'h018, 32'h000000A5);
		cmd(3'h7);
		repeat (12) @(posedge clk);
		chk(nFuse, 32'h00000000);
		dbgAccess <= 1'b1;
		cmd(3'h7);
		waitIdle;
		dbgAccess <= 1'b0;
		chk(nFuse, 32'h00000001);
		chk({24'h000000, fuseData}, 32'h000000A5);
		$display("test fuse write done");
		st(16'h1410, 8'h00);
		cmd(3'h1);
		@(posedge clk);
		sysRst <= 1'b1;
		repeat (2) @(posedge clk);
		sysRst <= 1'b0;
		repeat (100) @(posedge clk);
		pk(16'h1410, 8'hFF);
		rdchk(12'h008, 32'h00000000, 32'h00000003);
		rdchk(12'h004, 32'h00000000, 32'h00000003);
		$display("test reset abort done");
		st(16'h1300, 8'h00);
		st(16'h1301, 8'h00);
		cmd(3'h1);
		waitIdle;
		apb(1'b1, 12'h004, 32'h00000001);
		nStrobe = 0;
		cmd(3'h5);
		waitIdle;
		chk(nStrobe, 32'h00000880);
		pk(16'h8401, 8'hFF);
		pk(16'h1300, 8'h00);
		$display("test chip erase done");
		cmd(3'h2);
		waitIdle;
		pk(16'h1300, 8'h00);
		st(16'h1300, 8'hFF);
		cmd(3'h2);
		waitIdle;
		pk(16'h1300, 8'hFF);
		pk(16'h1301, 8'h00);
		rdchk(12'h010, 32'h00000001, 32'h00000001);
		$display("test user row erase done");
		finalReport;
	end
endmodule
